// ==== hdl/audio_infoframe_field_regs.sv ====
// Register bank reporting the fields of the latest audio infoframe.
//
// Register access is over an AXI4-Lite slave port (axil_register_port).
`default_nettype none

module audio_infoframe_field_regs
    import audio_if_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              frame_valid,
    input  wire audio_frame_s      frame_bytes,
    output var  audio_fields_s     audio_fields,
    output var  logic              irq,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [STRB_W-1:0] wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [DATA_W-1:0] rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready
);

    logic              changed;
    logic              wr_fire;
    logic [IDX_W-1:0]  wr_idx;
    logic [DATA_W-1:0] wr_data;
    logic              wr_lane0;
    logic              wr_hit;
    logic              rd_fire;
    logic [IDX_W-1:0]  rd_idx;
    logic [DATA_W-1:0] rd_value;
    logic              rd_hit;
    logic              audio_flag;
    logic              irq_status;
    logic              irq_mask;
    logic              flag_read;
    logic              status_clear;

    // ********************************************
    // Address decoding
    // ********************************************
    function automatic logic is_flag_copy(input logic [IDX_W-1:0] idx);
        if (idx == IDX_FLAGS_A) begin
            return 1'b1;
        end else if (idx == IDX_FLAGS_B) begin
            return 1'b1;
        end else if (idx == IDX_FLAGS_C) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    function automatic logic is_writable(input logic [IDX_W-1:0] idx);
        if (idx == IDX_IRQ_STATUS) begin
            return 1'b1;
        end else if (idx == IDX_IRQ_MASK) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // ********************************************
    // Sub-blocks
    // ********************************************
    infoframe_capture u_capture (
        .clk         (clk),
        .rst         (rst),
        .frame_valid (frame_valid),
        .frame_bytes (frame_bytes),
        .fields      (audio_fields),
        .changed     (changed)
    );

    axil_register_port u_port (
        .clk      (clk),
        .rst      (rst),
        .awaddr   (awaddr),
        .awvalid  (awvalid),
        .awready  (awready),
        .wdata    (wdata),
        .wstrb    (wstrb),
        .wvalid   (wvalid),
        .wready   (wready),
        .bresp    (bresp),
        .bvalid   (bvalid),
        .bready   (bready),
        .araddr   (araddr),
        .arvalid  (arvalid),
        .arready  (arready),
        .rdata    (rdata),
        .rresp    (rresp),
        .rvalid   (rvalid),
        .rready   (rready),
        .wr_fire  (wr_fire),
        .wr_idx   (wr_idx),
        .wr_data  (wr_data),
        .wr_lane0 (wr_lane0),
        .wr_hit   (wr_hit),
        .rd_fire  (rd_fire),
        .rd_idx   (rd_idx),
        .rd_value (rd_value),
        .rd_hit   (rd_hit)
    );

    // ********************************************
    // Read multiplexer
    // ********************************************
    assign wr_hit = is_writable(wr_idx);

    always_comb begin
        rd_value = '0;
        rd_hit   = 1'b1;
        if (rd_idx == IDX_CODING) begin
            rd_value[CODING_LSB +: 4] = audio_fields.coding_type_code;
            rd_value[CHAN_LSB +: 3] = audio_fields.channel_count_code;
        end else if (rd_idx == IDX_RATE) begin
            rd_value[RATE_LSB +: 3] = audio_fields.sample_rate_code;
            rd_value[SIZE_LSB +: 2] = audio_fields.sample_size_code;
        end else if (rd_idx == IDX_BITRATE) begin
            rd_value[7:0] = audio_fields.max_bitrate;
        end else if (rd_idx == IDX_SPEAKER) begin
            rd_value[7:0] = audio_fields.speaker_allocation_code;
        end else if (rd_idx == IDX_DOWNMIX) begin
            rd_value[PROHIBIT_BIT] = audio_fields.downmix_prohibit;
            rd_value[LEVEL_LSB +: 4] = audio_fields.level_shift_value;
        end else if (is_flag_copy(rd_idx)) begin
            rd_value[AUDIO_FLAG] = audio_flag;
        end else if (rd_idx == IDX_IRQ_STATUS) begin
            rd_value[IRQ_AUDIO] = irq_status;
        end else if (rd_idx == IDX_IRQ_MASK) begin
            rd_value[IRQ_AUDIO] = irq_mask;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // ********************************************
    // Change flag
    // ********************************************
    assign flag_read = rd_fire && is_flag_copy(rd_idx);

    always_ff @(posedge clk) begin
        if (rst) begin
            audio_flag <= 1'b0;
        end else if (changed) begin
            audio_flag <= 1'b1;
        end else if (flag_read) begin
            audio_flag <= 1'b0;
        end
    end

    // ********************************************
    // Interrupt status and mask
    // ********************************************
    assign status_clear = wr_fire && wr_lane0 &&
                          (wr_idx == IDX_IRQ_STATUS) && wr_data[IRQ_AUDIO];

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_status <= 1'b0;
        end else if (changed) begin
            irq_status <= 1'b1;
        end else if (status_clear) begin
            irq_status <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask <= 1'b0;
        end else if (wr_fire && wr_lane0 && (wr_idx == IDX_IRQ_MASK)) begin
            irq_mask <= wr_data[IRQ_AUDIO];
        end
    end

    assign irq = irq_status && irq_mask;

    // ********************************************
    // Assertions
    // ********************************************
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    sequence read_of(logic [IDX_W-1:0] idx);
        rd_fire && (rd_idx == idx);
    endsequence

    sequence answer_shows;
        rvalid && (rresp == RESP_OKAY);
    endsequence

    property coding_field;
        read_of(IDX_CODING) |=> answer_shows and
            (rdata[CODING_LSB +: 4] ==
             $past(audio_fields.coding_type_code));
    endproperty

    coding_pos_a: assert property (coding_field)
        else $error("coding type not in bits 7 to 4");

    coding_range_a: assert property (
        frame_valid |=> (audio_fields.coding_type_code ==
                         $past(frame_bytes.coding_chan[CODING_LSB +: 4])))
        else $error("coding type not taken from frame");

    channel_field_a: assert property (
        read_of(IDX_CODING) |=>
            rdata[CHAN_LSB +: 3] == $past(audio_fields.channel_count_code)
            && rdata[3] == 1'b0)
        else $error("channel count field wrong");

    rate_field_a: assert property (
        read_of(IDX_RATE) |=> answer_shows and
            (rdata[RATE_LSB +: 3] == $past(audio_fields.sample_rate_code)))
        else $error("sampling frequency field wrong");

    size_field_a: assert property (
        read_of(IDX_RATE) |=>
            rdata[SIZE_LSB +: 2] == $past(audio_fields.sample_size_code)
            && rdata[7:5] == 3'h0)
        else $error("sample size field wrong");

    bitrate_field_a: assert property (
        read_of(IDX_BITRATE) |=>
            rdata[7:0] == $past(audio_fields.max_bitrate))
        else $error("maximum bit rate wrong");

    speaker_field_a: assert property (
        frame_valid |=> audio_fields.speaker_allocation_code ==
            $past(frame_bytes.speaker))
        else $error("speaker allocation not as received");

    prohibit_bit_a: assert property (
        read_of(IDX_DOWNMIX) |=>
            rdata[PROHIBIT_BIT] == $past(audio_fields.downmix_prohibit))
        else $error("down-mix prohibit bit wrong");

    level_field_a: assert property (
        read_of(IDX_DOWNMIX) |=>
            rdata[LEVEL_LSB +: 4] == $past(audio_fields.level_shift_value)
            && rdata[2:0] == 3'h0)
        else $error("level shift field wrong");

    level_raw_a: assert property (
        frame_valid |=> (audio_fields.level_shift_value ==
                         $past(frame_bytes.downmix[LEVEL_LSB +: 4])))
        else $error("level shift code altered");

    flag_set_a: assert property (
        frame_valid && (audio_fields.max_bitrate != frame_bytes.bitrate)
        |-> ##2 audio_flag)
        else $error("change flag not raised");

    flag_clear_a: assert property (
        flag_read && !changed |=> !audio_flag ##0 rvalid &&
            rdata[AUDIO_FLAG] == $past(audio_flag))
        else $error("flag read did not clear");

    fields_hold_a: assert property (
        !frame_valid |=> $stable(audio_fields))
        else $error("fields moved without a frame");

    irq_level_a: assert property (
        changed ##1 irq_mask |-> irq)
        else $error("interrupt missing for unmasked event");

    unmapped_read_a: assert property (
        rd_fire && !rd_hit |=> rvalid && rresp == RESP_SLVERR
            && rdata == '0)
        else $error("unmapped read not refused");

    write_answer_a: assert property (
        wr_fire |=> bvalid ##0 (bresp == RESP_OKAY) == $past(wr_hit))
        else $error("write response wrong");

    speaker_read_a: assert property (
        read_of(IDX_SPEAKER) |=> answer_shows and
            (rdata[7:0] == $past(audio_fields.speaker_allocation_code)))
        else $error("speaker allocation read wrong");

    flag_wins_a: assert property (
        changed |=> audio_flag)
        else $error("change flag lost to a clear");

    flag_copy_a: assert property (
        rd_fire && is_flag_copy(rd_idx) |=> rvalid &&
            rdata == (DATA_W'($past(audio_flag)) << AUDIO_FLAG))
        else $error("flag copy read wrong");

    status_set_a: assert property (
        changed |=> irq_status)
        else $error("interrupt status not set");

    status_clear_a: assert property (
        status_clear && !changed |=> !irq_status)
        else $error("interrupt status not cleared");

    mask_write_a: assert property (
        wr_fire && wr_lane0 && (wr_idx == IDX_IRQ_MASK)
        |=> irq_mask == $past(wr_data[IRQ_AUDIO]))
        else $error("interrupt mask not written");

    lane_guard_a: assert property (
        wr_fire && !wr_lane0 |=> $stable(irq_mask))
        else $error("mask changed without byte lane");

    read_done_a: assert property (
        rvalid && rready |=> !rvalid)
        else $error("read answer repeated");

    write_done_a: assert property (
        bvalid && bready |=> !bvalid)
        else $error("write answer repeated");

    single_write_a: assert property (
        wr_fire |=> !wr_fire)
        else $error("write applied twice");

endmodule

`default_nettype wire

// ==== common/audio_if_pkg.sv ====
// Register map, field layout and carrier types of the audio field block.
`default_nettype none

package audio_if_pkg;

    // ********************************************
    // Bus geometry and register indices
    // ********************************************
    localparam int ADDR_W   = 10;
    localparam int IDX_W    = 8;
    localparam int WORD_LSB = 2;
    localparam int DATA_W   = 32;
    localparam int STRB_W   = DATA_W / 8;

    localparam logic [IDX_W-1:0] IDX_CODING     = 8'h91;
    localparam logic [IDX_W-1:0] IDX_RATE       = 8'h92;
    localparam logic [IDX_W-1:0] IDX_BITRATE    = 8'h93;
    localparam logic [IDX_W-1:0] IDX_SPEAKER    = 8'h94;
    localparam logic [IDX_W-1:0] IDX_DOWNMIX    = 8'h95;
    localparam logic [IDX_W-1:0] IDX_FLAGS_A    = 8'h87;
    localparam logic [IDX_W-1:0] IDX_FLAGS_B    = 8'h8f;
    localparam logic [IDX_W-1:0] IDX_FLAGS_C    = 8'h97;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'hc0;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 8'hc1;

    // ********************************************
    // Field positions
    // ********************************************
    localparam int CODING_LSB   = 4;
    localparam int CHAN_LSB     = 0;
    localparam int RATE_LSB     = 2;
    localparam int SIZE_LSB     = 0;
    localparam int PROHIBIT_BIT = 7;
    localparam int LEVEL_LSB    = 3;
    localparam int AUDIO_FLAG   = 1;
    localparam int IRQ_AUDIO    = 0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************************
    // Carrier types
    // ********************************************
    typedef struct packed {
        logic [7:0] coding_chan;
        logic [7:0] rate_size;
        logic [7:0] bitrate;
        logic [7:0] speaker;
        logic [7:0] downmix;
    } audio_frame_s;

    typedef struct packed {
        logic [3:0] coding_type_code;
        logic [2:0] channel_count_code;
        logic [2:0] sample_rate_code;
        logic [1:0] sample_size_code;
        logic [7:0] max_bitrate;
        logic [7:0] speaker_allocation_code;
        logic       downmix_prohibit;
        logic [3:0] level_shift_value;
    } audio_fields_s;

    localparam audio_fields_s FIELDS_RESET = '0;

endpackage

`default_nettype wire

// ==== hdl/infoframe_capture.sv ====
// Holder of the decoded audio infoframe fields with change detection.
`default_nettype none

module infoframe_capture
    import audio_if_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          frame_valid,
    input  wire audio_frame_s  frame_bytes,
    output var  audio_fields_s fields,
    output var  logic          changed
);

    audio_fields_s next_fields;

    // ********************************************
    // Unpacking of the received bytes
    // ********************************************
    always_comb begin
        next_fields = FIELDS_RESET;
        next_fields.coding_type_code =
            frame_bytes.coding_chan[CODING_LSB +: 4];
        next_fields.channel_count_code =
            frame_bytes.coding_chan[CHAN_LSB +: 3];
        next_fields.sample_rate_code =
            frame_bytes.rate_size[RATE_LSB +: 3];
        next_fields.sample_size_code =
            frame_bytes.rate_size[SIZE_LSB +: 2];
        next_fields.max_bitrate = frame_bytes.bitrate;
        next_fields.speaker_allocation_code = frame_bytes.speaker;
        next_fields.downmix_prohibit = frame_bytes.downmix[PROHIBIT_BIT];
        next_fields.level_shift_value =
            frame_bytes.downmix[LEVEL_LSB +: 4];
    end

    // ********************************************
    // Field store
    // ********************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            fields  <= FIELDS_RESET;
            changed <= 1'b0;
        end else begin
            changed <= frame_valid && (next_fields != fields);
            if (frame_valid) begin
                fields <= next_fields;
            end
        end
    end

endmodule

`default_nettype wire

// ==== hdl/axil_register_port.sv ====
// AXI4-Lite slave front end that turns bus traffic into register strobes.
`default_nettype none

module axil_register_port
    import audio_if_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [STRB_W-1:0] wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [DATA_W-1:0] rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    output var  logic              wr_fire,
    output var  logic [IDX_W-1:0]  wr_idx,
    output var  logic [DATA_W-1:0] wr_data,
    output var  logic              wr_lane0,
    input  wire logic              wr_hit,
    output var  logic              rd_fire,
    output var  logic [IDX_W-1:0]  rd_idx,
    input  wire logic [DATA_W-1:0] rd_value,
    input  wire logic              rd_hit
);

    logic              aw_held;
    logic              w_held;
    logic [STRB_W-1:0] w_strb;

    // ********************************************
    // Write channels
    // ********************************************
    assign awready  = !aw_held;
    assign wready   = !w_held;
    assign wr_fire  = aw_held && w_held && !bvalid;
    assign wr_lane0 = w_strb[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            wr_idx  <= '0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            wr_idx  <= awaddr[WORD_LSB +: IDX_W];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_held  <= 1'b0;
            wr_data <= '0;
            w_strb  <= '0;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end else if (wvalid && wready) begin
            w_held  <= 1'b1;
            wr_data <= wdata;
            w_strb  <= wstrb;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ********************************************
    // Read channels
    // ********************************************
    assign arready = !rvalid;
    assign rd_fire = arvalid && arready;
    assign rd_idx  = araddr[WORD_LSB +: IDX_W];

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata  <= rd_value;
            rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ==== tb/infoframe_source.sv ====
// Behavioural video source that delivers audio infoframes.
`default_nettype none

module infoframe_source
    import audio_if_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         send,
    input  wire audio_frame_s frame_in,
    output var  logic         frame_valid,
    output var  audio_frame_s frame_bytes
);
    timeunit 1ns;
    timeprecision 1ns;

    audio_frame_s last;

    // ************************************************
    // Frame delivery, bytes scrambled between frames
    // ************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_valid <= 1'b0;
            frame_bytes <= '0;
            last        <= '0;
        end else if (send) begin
            frame_valid <= 1'b1;
            frame_bytes <= frame_in;
            last        <= frame_in;
        end else begin
            frame_valid <= 1'b0;
            frame_bytes <= ~last;
        end
    end
endmodule

`default_nettype wire

// ==== tb/tb_audio_infoframe_field_regs.sv ====
// Self-checking bench of the audio infoframe register bank.
`default_nettype none

module tb_audio_infoframe_field_regs
    import audio_if_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] FLAG_BIT = 8'(1 << AUDIO_FLAG);

    logic              clk, rst, send, frame_valid, irq;
    audio_frame_s      frame_in, frame_bytes, f;
    audio_fields_s     audio_fields;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [DATA_W-1:0] wdata, rdata;
    logic [STRB_W-1:0] wstrb;
    logic [1:0]        bresp, rresp;
    logic [33:0]       rd_q[$];
    logic [1:0]        wr_q[$];
    logic [31:0]       seed;
    logic [33:0]       r;
    logic [IDX_W-1:0]  flag_idx[3];
    int                mismatches, n_checks, cycles;

    infoframe_source i_src (.clk, .rst, .send, .frame_in, .frame_valid,
                            .frame_bytes);

    audio_infoframe_field_regs i_dut (.clk, .rst, .frame_valid,
        .frame_bytes, .audio_fields, .irq, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(string name, logic [39:0] exp, logic [39:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic axi_read(logic [IDX_W-1:0] idx, logic [7:0] exp,
                            logic [1:0] resp);
        logic ar_ok;
        logic r_ok;
        rd_q.push_back({resp, 24'h0, exp});
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        r_ok = 1'b0;
        while (!r_ok) begin
            @(negedge clk);
            ar_ok = arvalid && arready;
            r_ok  = rvalid && rready;
            @(posedge clk);
            if (ar_ok) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_write(logic [IDX_W-1:0] idx, logic [7:0] data,
                             logic [3:0] strb, logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        logic b_ok;
        wr_q.push_back(resp);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, data};
        wstrb   <= strb;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        b_ok = 1'b0;
        while (!b_ok) begin
            @(negedge clk);
            aw_ok = awvalid && awready;
            w_ok  = wvalid && wready;
            b_ok  = bvalid && bready;
            @(posedge clk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic send_frame(audio_frame_s fr);
        send     <= 1'b1;
        frame_in <= fr;
        @(posedge clk);
        send <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic check_irq(logic exp);
        @(negedge clk);
        check("irq", 40'(exp), 40'(irq));
        @(posedge clk);
    endtask

    task automatic check_frame(audio_frame_s fr);
        audio_fields_s e;
        e = {fr.coding_chan[7:4], fr.coding_chan[2:0], fr.rate_size[4:0],
             fr.bitrate, fr.speaker, fr.downmix[7:3]};
        check("fields", 40'(e), 40'(audio_fields));
        axi_read(IDX_CODING, fr.coding_chan, RESP_OKAY);
        axi_read(IDX_RATE, fr.rate_size, RESP_OKAY);
        axi_read(IDX_BITRATE, fr.bitrate, RESP_OKAY);
        axi_read(IDX_SPEAKER, fr.speaker, RESP_OKAY);
        axi_read(IDX_DOWNMIX, fr.downmix, RESP_OKAY);
    endtask

    // ************************************************
    // Response monitor
    // ************************************************
    always @(posedge clk) begin
        if (rvalid && rready) begin
            r = rd_q.pop_front();
            check("rdata", 40'(r[31:0]), 40'(rdata));
            check("rresp", 40'(r[33:32]), 40'(rresp));
        end
        if (bvalid && bready)
            check("bresp", 40'(wr_q.pop_front()), 40'(bresp));
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        rst = 1'b1;
        {send, frame_in, awaddr, awvalid, wdata, wstrb} = '0;
        {wvalid, bready, araddr, arvalid, rready} = '0;
        seed = 32'd53;
        flag_idx = '{IDX_FLAGS_A, IDX_FLAGS_B, IDX_FLAGS_C};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_frame('0);
        for (int i = 0; i < 9; i++) begin
            f = {8'(xs()), xs()};
            f.coding_chan = {4'(i), 1'b0, 3'(i)};
            f.rate_size   = {3'h0, 3'(i), 2'(i)};
            f.downmix[2:0] = 3'h0;
            send_frame(f);
            check_frame(f);
            axi_read(flag_idx[i % 3], FLAG_BIT, RESP_OKAY);
            axi_read(flag_idx[(i + 1) % 3], 8'h00, RESP_OKAY);
        end
        send_frame(f);
        axi_read(IDX_FLAGS_B, 8'h00, RESP_OKAY);
        check_frame(f);
        check_irq(1'b0);
        axi_read(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
        axi_write(IDX_IRQ_MASK, 8'h01, 4'he, RESP_OKAY);
        check_irq(1'b0);
        axi_write(IDX_IRQ_MASK, 8'h01, 4'hf, RESP_OKAY);
        check_irq(1'b1);
        axi_read(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
        axi_write(IDX_IRQ_STATUS, 8'h01, 4'hf, RESP_OKAY);
        check_irq(1'b0);
        axi_read(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
        f.speaker = ~f.speaker;
        send_frame(f);
        check_irq(1'b1);
        axi_read(8'h96, 8'h00, RESP_SLVERR);
        axi_write(IDX_RATE, 8'h00, 4'hf, RESP_SLVERR);
        axi_write(8'h96, 8'h00, 4'hf, RESP_SLVERR);
        check_frame(f);
        finish_test();
    end
endmodule

`default_nettype wire
